// >>> src/rbx_reset_bank_map.sv
// Reset bank tracking, code bank map, data memory decode and strobe control
`timescale 1ns/10ps
module rbx_reset_bank_map
    import rbx_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic watchdog_reset_i,
    input wire logic low_supply_i,
    input wire logic [15:0] code_addr_i,
    input wire logic code_table_read_i,
    input wire rbx_sfr_req_type sfr_req_i,
    input wire rbx_xdata_req_type xdata_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic [7:0] xdata_rdata_o,
    output logic core_reset_o,
    output logic [15:0] pc_load_addr_o,
    output logic pc_load_o,
    output logic brownout_irq_o,
    output logic boot_code_sel_o,
    output rbx_bank_type bank_o,
    output logic lower_ram_sel_o,
    output logic upper_ram_sel_o,
    output logic sfr_sel_o,
    output logic [7:0] sfr_other_addr_o,
    output logic sfr_other_sel_o,
    output logic sfr_soft_reset_o,
    output logic expanded_data_ram_sel_o,
    output logic ext_bus_cycle_o,
    output logic ext_rd_n_o,
    output logic ext_wr_n_o,
    output logic [15:0] ext_addr_o,
    output logic [7:0] ext_wdata_o,
    output logic addr_latch_o
);
    rbx_bank_type bank_reg;
    rbx_bank_type bank_next;
    logic [7:0] aux_mem_reg;
    logic [7:0] aux_irq_reg;
    logic [7:0] wdt_ctrl_reg;
    logic ale_phase_reg;
    logic ext_wr_n_reg;
    logic ext_rd_n_reg;
    logic [15:0] ext_addr_reg;
    logic [7:0] ext_wdata_reg;
    logic [7:0] sfr_rdata_reg;
    logic bo_reset;
    logic bo_irq;
    logic [7:0] expanded_data_ram_rdata;

    // ==========================================================
    // Register access decode
    wire logic sfr_direct = sfr_req_i.req && !sfr_req_i.indirect;
    wire logic sfr_wr = sfr_direct && sfr_req_i.wr;
    wire logic wr_aux = sfr_wr && sfr_req_i.addr == RBX_AUX_MEM_CTRL_ADDR;
    wire logic wr_fcf = sfr_wr && sfr_req_i.addr == RBX_FLASH_CONFIG_ADDR;
    wire logic wr_iea = sfr_wr && sfr_req_i.addr == RBX_AUX_IRQ_ENABLE_ADDR;
    wire logic wr_watchdog_control_reg =
        sfr_wr && sfr_req_i.addr == RBX_WATCHDOG_CONTROL_ADDR;
    wire logic own_addr = sfr_req_i.addr == RBX_AUX_MEM_CTRL_ADDR ||
        sfr_req_i.addr == RBX_FLASH_CONFIG_ADDR ||
        sfr_req_i.addr == RBX_AUX_IRQ_ENABLE_ADDR ||
        sfr_req_i.addr == RBX_WATCHDOG_CONTROL_ADDR;

    // ==========================================================
    // Reset sources
    // Only a zero-to-one edge of the flag retriggers
    wire logic soft_reset = wr_fcf &&
        sfr_req_i.wdata[RBX_FCF_SOFT_RESET_BIT] &&
        !bank_reg.soft_reset_flag;
    wire logic hard_reset = sys_rst_i;
    wire logic warm_reset = watchdog_reset_i || bo_reset;
    wire logic any_reset = hard_reset || warm_reset || soft_reset;

    rbx_brownout_filter u_brownout (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .low_supply_i(low_supply_i),
        .irq_enable_i(aux_irq_reg[RBX_IEA_BROWNOUT_EN_BIT]),
        .brownout_reset_o(bo_reset),
        .brownout_irq_o(bo_irq)
    );

    // ==========================================================
    // Bank bits
    always_comb begin
        bank_next = bank_reg;
        if (hard_reset) begin
            bank_next = '0;
        end else if (soft_reset) begin
            bank_next.soft_reset_flag = 1'b1;
            bank_next.code_bank_select = 1'b0;
        end else if (warm_reset) begin
            bank_next.code_bank_select = 1'b0;
        end else if (wr_fcf) begin
            bank_next.soft_reset_flag =
                sfr_req_i.wdata[RBX_FCF_SOFT_RESET_BIT];
            bank_next.code_bank_select =
                sfr_req_i.wdata[RBX_FCF_BANK_SELECT_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        bank_reg <= bank_next;
    end

    // ==========================================================
    // Other control registers
    always_ff @(posedge sys_clk_i) begin
        if (any_reset) begin
            aux_mem_reg <= RBX_AUX_MEM_CTRL_RST;
            aux_irq_reg <= RBX_AUX_IRQ_ENABLE_RST;
        end else begin
            if (wr_aux) begin
                // Reserved bits held at zero
                aux_mem_reg <= {6'h00, sfr_req_i.wdata[1:0]};
            end
            if (wr_iea) begin
                aux_irq_reg <= sfr_req_i.wdata;
            end
        end
    end

    // Bit 2 of watchdog control survives a software reset
    always_ff @(posedge sys_clk_i) begin
        if (hard_reset || warm_reset) begin
            wdt_ctrl_reg <= RBX_WATCHDOG_CONTROL_RST;
        end else if (soft_reset) begin
            wdt_ctrl_reg <= RBX_WATCHDOG_CONTROL_RST |
                (wdt_ctrl_reg & (8'h01 << RBX_WATCHDOG_CONTROL_REG_KEEP_BIT));
        end else if (wr_watchdog_control_reg) begin
            wdt_ctrl_reg <= sfr_req_i.wdata;
        end
    end

    // ==========================================================
    // Core reset and vector load
    assign core_reset_o = any_reset;
    assign sfr_soft_reset_o = soft_reset;
    assign pc_load_o = any_reset || bo_irq;
    assign pc_load_addr_o = (bo_irq && !any_reset) ?
        RBX_BROWNOUT_VECTOR : RBX_RESET_VECTOR;
    assign brownout_irq_o = bo_irq && !any_reset;

    // ==========================================================
    // Code bank map
    assign bank_o = bank_reg;
    assign boot_code_sel_o = code_addr_i <= RBX_BOOT_TOP &&
        !bank_reg.soft_reset_flag &&
        !bank_reg.code_bank_select;

    // ==========================================================
    // Internal data decode
    wire logic is_lower = sfr_req_i.addr <= RBX_LOWER_RAM_TOP;
    assign lower_ram_sel_o = sfr_req_i.req && is_lower;
    assign upper_ram_sel_o = sfr_req_i.req && !is_lower &&
        sfr_req_i.indirect;
    assign sfr_sel_o = sfr_req_i.req && !is_lower && !sfr_req_i.indirect;
    assign sfr_other_sel_o = sfr_sel_o && !own_addr;
    assign sfr_other_addr_o = sfr_req_i.addr;

    wire logic [7:0] sfr_rd_mux =
        sfr_req_i.addr == RBX_AUX_MEM_CTRL_ADDR ? aux_mem_reg :
        sfr_req_i.addr == RBX_FLASH_CONFIG_ADDR ?
            {6'h00, bank_reg.soft_reset_flag, bank_reg.code_bank_select} :
        sfr_req_i.addr == RBX_AUX_IRQ_ENABLE_ADDR ? aux_irq_reg :
        sfr_req_i.addr == RBX_WATCHDOG_CONTROL_ADDR ? wdt_ctrl_reg : 8'h00;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sfr_rdata_reg <= 8'h00;
        end else if (sfr_direct && !is_lower) begin
            sfr_rdata_reg <= sfr_rd_mux;
        end
    end
    assign sfr_rdata_o = sfr_rdata_reg;

    // ==========================================================
    // External data move routing
    wire logic force_ext = aux_mem_reg[RBX_AUX_FORCE_XDATA_BIT];
    // Byte-register moves give an 8-bit address, which is always in range
    wire logic in_expanded_data_ram = !xdata_req_i.via_pointer ||
        xdata_req_i.addr <= RBX_EXPANDED_DATA_RAM_TOP;
    assign expanded_data_ram_sel_o = xdata_req_i.req && !force_ext && in_expanded_data_ram;
    assign ext_bus_cycle_o = xdata_req_i.req && !expanded_data_ram_sel_o;

    // Byte-register moves carry only an 8-bit address; upper bits ignored
    wire logic [9:0] expanded_data_ram_addr = xdata_req_i.via_pointer ?
        xdata_req_i.addr[9:0] : {2'h0, xdata_req_i.addr[7:0]};

    rbx_expanded_data_ram u_expanded_data_ram (
        .sys_clk_i(sys_clk_i),
        .wr_i(expanded_data_ram_sel_o && xdata_req_i.wr),
        .addr_i(expanded_data_ram_addr),
        .wdata_i(xdata_req_i.wdata),
        .rdata_o(expanded_data_ram_rdata)
    );
    assign xdata_rdata_o = expanded_data_ram_rdata;

    // Pins only move for off-chip cycles
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ext_wr_n_reg <= 1'b1;
            ext_rd_n_reg <= 1'b1;
            ext_addr_reg <= 16'h0000;
            ext_wdata_reg <= 8'h00;
        end else begin
            ext_wr_n_reg <= !(ext_bus_cycle_o && xdata_req_i.wr);
            ext_rd_n_reg <= !(ext_bus_cycle_o && !xdata_req_i.wr);
            if (ext_bus_cycle_o) begin
                ext_addr_reg <= xdata_req_i.addr;
                ext_wdata_reg <= xdata_req_i.wdata;
            end
        end
    end
    assign ext_wr_n_o = ext_wr_n_reg;
    assign ext_rd_n_o = ext_rd_n_reg;
    assign ext_addr_o = ext_addr_reg;
    assign ext_wdata_o = ext_wdata_reg;

    // ==========================================================
    // Address latch strobe
    // Divide by two gives the half-rate strobe
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ale_phase_reg <= 1'b0;
        end else begin
            ale_phase_reg <= !ale_phase_reg;
        end
    end
    wire logic strobe_suppress = aux_mem_reg[RBX_AUX_STROBE_SUPPRESS_BIT];
    wire logic ale_demand = ext_bus_cycle_o || code_table_read_i;
    assign addr_latch_o = ale_phase_reg &&
        (!strobe_suppress || ale_demand);
endmodule

// >>> src/rbx_pkg.sv
// Package: constants and carrier types for the reset bank and data map block
// Summary of operation
// - Software reset starts when the soft reset flag goes from zero to one.
// - Software reset zeroes the program counter and forces flag pair to one-zero.
// - Software reset keeps watchdog control bit 2 and RAM; other registers reset.
// - Brownout acts only after low supply persists four clock periods.
// - Brownout without its interrupt enabled resets and restarts at zero.
// - Brownout with interrupt enabled raises an interrupt vectoring to 004BH.
// - Clearing the brownout interrupt enable during brownout causes a reset.
// - Brownout reset clears bank select and keeps the soft reset flag.
// - Watchdog reset clears bank select and keeps the soft reset flag.
// - External and power-on resets clear both flags, mapping boot code low.
// - After watchdog or brownout, pair 00 maps boot code, 10 user code.
// - Data addresses 00H to 7FH reach lower RAM, direct and indirect.
// - Upper addresses: indirect reaches upper RAM, direct reaches special registers.
// - With force bit clear, moves to 000H-2FFH reach on-chip expanded RAM.
// - With force bit clear, moves above expanded RAM go off-chip.
// - With force bit set, every external data move goes off-chip.
// - Expanded RAM accesses leave ports 0, 2 and read/write strobes idle.
// - Strobe suppress zero: latch strobe at half clock; one: only during off-chip moves and code table reads.
// - Boot code is mapped low only when both flags are zero.
package rbx_pkg;

    // ==========================================================
    // Register offsets and fields
    localparam logic [7:0] RBX_AUX_MEM_CTRL_ADDR = 8'h8e;
    localparam logic [7:0] RBX_AUX_MEM_CTRL_RST = 8'h00;
    localparam int RBX_AUX_FORCE_XDATA_BIT = 1;
    localparam int RBX_AUX_STROBE_SUPPRESS_BIT = 0;
    localparam logic [7:0] RBX_FLASH_CONFIG_ADDR = 8'hb1;
    localparam int RBX_FCF_SOFT_RESET_BIT = 1;
    localparam int RBX_FCF_BANK_SELECT_BIT = 0;
    localparam logic [7:0] RBX_WATCHDOG_CONTROL_ADDR = 8'hc0;
    localparam logic [7:0] RBX_WATCHDOG_CONTROL_RST = 8'h00;
    localparam int RBX_WATCHDOG_CONTROL_REG_KEEP_BIT = 2;
    localparam logic [7:0] RBX_AUX_IRQ_ENABLE_ADDR = 8'ha7;
    localparam logic [7:0] RBX_AUX_IRQ_ENABLE_RST = 8'h00;
    localparam int RBX_IEA_BROWNOUT_EN_BIT = 3;

    // ==========================================================
    // Address map
    localparam logic [7:0] RBX_LOWER_RAM_TOP = 8'h7f;
    localparam logic [15:0] RBX_EXPANDED_DATA_RAM_TOP = 16'h02ff;
    localparam logic [15:0] RBX_BOOT_TOP = 16'h1fff;
    localparam logic [15:0] RBX_RESET_VECTOR = 16'h0000;
    localparam logic [15:0] RBX_BROWNOUT_VECTOR = 16'h004b;
    localparam int RBX_EXPANDED_DATA_RAM_DEPTH = 768;

    // ==========================================================
    // Timing
    localparam int RBX_BROWNOUT_FILTER_CYCLES = 4;
    localparam int RBX_ALE_DIVIDE = 2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        RBX_DATA_LOWER_RAM = 2'b00,
        RBX_DATA_UPPER_RAM = 2'b01,
        RBX_DATA_SFR = 2'b11
    } rbx_data_target_type;

    typedef struct packed {
        logic soft_reset_flag;
        logic code_bank_select;
    } rbx_bank_type;

    typedef struct packed {
        logic req;
        logic wr;
        logic indirect;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rbx_sfr_req_type;

    typedef struct packed {
        logic req;
        logic wr;
        logic via_pointer;
        logic [15:0] addr;
        logic [7:0] wdata;
    } rbx_xdata_req_type;

endpackage

// >>> src/rbx_brownout_filter.sv
// Brownout persistence filter and interrupt versus reset decision
`timescale 1ns/10ps
module rbx_brownout_filter
    import rbx_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic low_supply_i,
    input wire logic irq_enable_i,
    output logic brownout_reset_o,
    output logic brownout_irq_o
);
    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic active_reg;
    logic irq_en_d_reg;
    wire logic qualified;
    wire logic rise;

    // ==========================================================
    // Filter
    assign qualified = (count_reg >= 3'(RBX_BROWNOUT_FILTER_CYCLES));
    assign count_next = !low_supply_i ? 3'h0 :
        (qualified ? count_reg : count_reg + 3'h1);
    assign rise = qualified && !active_reg;
    // Reset unless enabled; dropping the enable mid-brownout also resets
    assign brownout_reset_o = (rise && !irq_enable_i) ||
        (qualified && irq_en_d_reg && !irq_enable_i);
    assign brownout_irq_o = rise && irq_enable_i;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            count_reg <= 3'h0;
            active_reg <= 1'b0;
            irq_en_d_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            active_reg <= qualified;
            irq_en_d_reg <= irq_enable_i;
        end
    end
endmodule

// >>> src/rbx_expanded_data_ram.sv
// On-chip expanded data RAM, 768 bytes
`timescale 1ns/10ps
module rbx_expanded_data_ram
    import rbx_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic wr_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    // No reset: contents survive every reset source
    logic [7:0] mem [RBX_EXPANDED_DATA_RAM_DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule

// >>> dv/rbx_reset_bank_map_asserts.sv
// Concurrent checks on the reset bank and data map ports
`timescale 1ns/10ps
module rbx_reset_bank_map_asserts
    import rbx_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic watchdog_reset_i,
    input wire logic low_supply_i,
    input wire logic [15:0] code_addr_i,
    input wire rbx_sfr_req_type sfr_req_i,
    input wire logic core_reset_o,
    input wire logic [15:0] pc_load_addr_o,
    input wire logic pc_load_o,
    input wire logic brownout_irq_o,
    input wire logic boot_code_sel_o,
    input wire rbx_bank_type bank_o,
    input wire logic lower_ram_sel_o,
    input wire logic upper_ram_sel_o,
    input wire logic sfr_sel_o,
    input wire logic expanded_data_ram_sel_o,
    input wire logic ext_rd_n_o,
    input wire logic ext_wr_n_o,
    input wire logic addr_latch_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ====
    // Shadow of the strobe suppress bit, cleared by every reset kind
    logic sup_reg;
    wire dir_wr = sfr_req_i.req && sfr_req_i.wr && !sfr_req_i.indirect;
    wire fcf_wr = dir_wr && sfr_req_i.addr == RBX_FLASH_CONFIG_ADDR
        && sfr_req_i.wdata[RBX_FCF_SOFT_RESET_BIT];
    wire aux_wr = dir_wr && sfr_req_i.addr == RBX_AUX_MEM_CTRL_ADDR;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || core_reset_o) begin
            sup_reg <= 1'b0;
        end else if (aux_wr) begin
            sup_reg <= sfr_req_i.wdata[RBX_AUX_STROBE_SUPPRESS_BIT];
        end
    end
    // ====
    // Properties
    sequence s_low_rise;
        !low_supply_i ##1 low_supply_i;
    endsequence
    property p_soft;
        fcf_wr && !bank_o.soft_reset_flag |->
            ##[0:1] core_reset_o ##1 bank_o == 2'b10;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset");
    property p_hard;
        $fell(sys_rst_i) |-> bank_o == 2'b00;
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset");
    property p_wdt;
        watchdog_reset_i && !fcf_wr |=> !bank_o.code_bank_select
            && bank_o.soft_reset_flag == $past(bank_o.soft_reset_flag);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog bank");
    property p_boot;
        boot_code_sel_o == (code_addr_i <= RBX_BOOT_TOP && bank_o == 2'b00);
    endproperty
    a_boot: assert property (p_boot) else $error("boot map");
    property p_decode;
        sfr_req_i.req |-> lower_ram_sel_o == !sfr_req_i.addr[7]
            && upper_ram_sel_o == (sfr_req_i.addr[7] && sfr_req_i.indirect)
            && sfr_sel_o == (sfr_req_i.addr[7] && !sfr_req_i.indirect);
    endproperty
    a_decode: assert property (p_decode) else $error("decode");
    property p_bo_wait;
        s_low_rise ##1 low_supply_i[*2] |=> !pc_load_o && !brownout_irq_o;
    endproperty
    a_bo_wait: assert property (p_bo_wait) else $error("early");
    property p_bo_act;
        s_low_rise ##1 low_supply_i[*3] |-> ##[0:2] pc_load_o;
    endproperty
    a_bo_act: assert property (p_bo_act) else $error("no act");
    property p_irq_vec;
        brownout_irq_o |-> pc_load_o && pc_load_addr_o == RBX_BROWNOUT_VECTOR;
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("irq vector");
    property p_rst_vec;
        core_reset_o && !brownout_irq_o |->
            pc_load_o && pc_load_addr_o == RBX_RESET_VECTOR;
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("vector");
    property p_expanded_data_ram_quiet;
        expanded_data_ram_sel_o && $past(ext_rd_n_o) && $past(ext_wr_n_o) |=>
            ext_rd_n_o && ext_wr_n_o;
    endproperty
    a_expanded_data_ram_quiet: assert property (p_expanded_data_ram_quiet) else $error("pins");
    property p_ale;
        !sup_reg && !$past(sup_reg) && !core_reset_o && !$past(core_reset_o)
            && !$past(sys_rst_i) |-> addr_latch_o != $past(addr_latch_o);
    endproperty
    a_ale: assert property (p_ale) else $error("latch rate");
endmodule

bind rbx_reset_bank_map rbx_reset_bank_map_asserts i_asserts (
    .sys_clk_i, .sys_rst_i, .watchdog_reset_i, .low_supply_i, .code_addr_i,
    .sfr_req_i, .core_reset_o, .pc_load_addr_o, .pc_load_o, .brownout_irq_o,
    .boot_code_sel_o, .bank_o, .lower_ram_sel_o, .upper_ram_sel_o,
    .sfr_sel_o, .expanded_data_ram_sel_o, .ext_rd_n_o, .ext_wr_n_o, .addr_latch_o
);

// >>> dv/rbx_core_model.sv
// Core-side model issuing internal and external data requests
`timescale 1ns/10ps
module rbx_core_model
    import rbx_pkg::*;
(
    output rbx_sfr_req_type sfr_req_o,
    output rbx_xdata_req_type xdata_req_o
);
    // ====
    // Request tasks, called just after a rising edge
    initial begin
        sfr_req_o = '0;
        xdata_req_o = '0;
    end
    task automatic sfr(input logic wr, ind, input logic [7:0] a, d);
        sfr_req_o = '{1'b1, wr, ind, a, d};
    endtask
    task automatic xd(input logic wr, ptr, input logic [15:0] a,
                      input logic [7:0] d);
        xdata_req_o = '{1'b1, wr, ptr, a, d};
    endtask
    // Released fields flip so stale values never pass for valid ones
    task automatic idle();
        sfr_req_o = {1'b0, ~sfr_req_o[17:0]};
        xdata_req_o = {1'b0, ~xdata_req_o[25:0]};
    endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the reset bank and data map block
`timescale 1ns/10ps
module tb_top;
    import rbx_pkg::*;
    typedef struct packed {
        logic xd;
        logic mode;
        logic frc;
        logic [15:0] a;
        logic [4:0] sel;
    } rbx_row_type;
    // Row sel is lower, upper, special, expanded, external
    rbx_row_type rows [10] = '{'{0, 0, 0, 16'h0000, 5'h10},
        '{0, 1, 0, 16'h007f, 5'h10}, '{0, 1, 0, 16'h0080, 5'h08},
        '{0, 0, 0, 16'h00ff, 5'h04}, '{1, 1, 0, 16'h0000, 5'h02},
        '{1, 1, 0, 16'h02ff, 5'h02}, '{1, 1, 0, 16'h0300, 5'h01},
        '{1, 0, 0, 16'h00a0, 5'h02}, '{1, 1, 1, 16'h00a0, 5'h01},
        '{1, 0, 1, 16'h0010, 5'h01}};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i, watchdog_reset_i, low_supply_i, code_table_read_i;
    logic [15:0] code_addr_i, pc_load_addr_o, ext_addr_o;
    wire rbx_sfr_req_type sfr_req_i;
    wire rbx_xdata_req_type xdata_req_i;
    logic [7:0] sfr_rdata_o, xdata_rdata_o, rd, sfr_other_addr_o, ext_wdata_o;
    logic core_reset_o, pc_load_o, brownout_irq_o, boot_code_sel_o;
    logic lower_ram_sel_o, upper_ram_sel_o, sfr_sel_o, expanded_data_ram_sel_o;
    logic ext_bus_cycle_o, ext_rd_n_o, ext_wr_n_o, addr_latch_o;
    logic rst_seen, irq_seen, srst_seen, sfr_other_sel_o, sfr_soft_reset_o;
    rbx_bank_type bank_o;
    int bad_count = 0;
    int checked = 0;
    int n;
    rbx_core_model i_rbx_core_model (.sfr_req_o(sfr_req_i),
        .xdata_req_o(xdata_req_i));
    rbx_reset_bank_map i_rbx_reset_bank_map (.sys_clk_i, .sys_rst_i,
        .watchdog_reset_i, .low_supply_i, .code_addr_i, .code_table_read_i,
        .sfr_req_i, .xdata_req_i, .sfr_rdata_o, .xdata_rdata_o,
        .core_reset_o, .pc_load_addr_o, .pc_load_o, .brownout_irq_o,
        .boot_code_sel_o, .bank_o, .lower_ram_sel_o, .upper_ram_sel_o,
        .sfr_sel_o, .sfr_other_addr_o, .sfr_other_sel_o,
        .sfr_soft_reset_o, .expanded_data_ram_sel_o, .ext_bus_cycle_o, .ext_rd_n_o,
        .ext_wr_n_o, .ext_addr_o, .ext_wdata_o, .addr_latch_o);
    // ====
    // Clock, sticky event capture and helpers
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (core_reset_o === 1'b1) rst_seen <= 1'b1;
        if (brownout_irq_o === 1'b1) irq_seen <= 1'b1;
        if (sfr_soft_reset_o === 1'b1) srst_seen <= 1'b1;
    end
    task automatic cyc();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            $display("Error at %0t ns: %s", $time, m);
            bad_count++;
        end
    endtask
    task automatic sfr_wr(input logic [7:0] a, d);
        i_rbx_core_model.sfr(1'b1, 1'b0, a, d);
        cyc();
        i_rbx_core_model.idle();
        cyc();
    endtask
    task automatic sfr_rd(input logic [7:0] a);
        i_rbx_core_model.sfr(1'b0, 1'b0, a, 8'h00);
        cyc();
        rd = sfr_rdata_o;
        i_rbx_core_model.idle();
        cyc();
    endtask
    task automatic latch_count(input int c);
        n = 0;
        repeat (c) begin
            cyc();
            n += int'(addr_latch_o === 1'b1);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole sequence needs about 130 cycles
    initial begin
        #50000;
        $display("Error at %0t ns: timeout", $time);
        bad_count++;
        complete_run();
    end
    // ====
    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        watchdog_reset_i = 1'b0;
        low_supply_i = 1'b0;
        code_table_read_i = 1'b0;
        code_addr_i = 16'h0000;
        repeat (16) cyc();
        sys_rst_i = 1'b0;
        chk(bank_o === 2'b00 && ext_rd_n_o === 1'b1, "reset state");
        sfr_rd(RBX_AUX_MEM_CTRL_ADDR);
        chk(rd === RBX_AUX_MEM_CTRL_RST, "aux reset value");
        $display("Test reset done");
        foreach (rows[i]) begin
            sfr_wr(RBX_AUX_MEM_CTRL_ADDR, {6'h00, rows[i].frc, 1'b0});
            if (rows[i].xd) begin
                i_rbx_core_model.xd(1'b0, rows[i].mode, rows[i].a, 8'h00);
            end else begin
                i_rbx_core_model.sfr(1'b0, rows[i].mode, rows[i].a[7:0], 8'h00);
            end
            #5;
            chk({lower_ram_sel_o, upper_ram_sel_o, sfr_sel_o, expanded_data_ram_sel_o,
                ext_bus_cycle_o} === rows[i].sel
                && sfr_other_sel_o === rows[i].sel[2]
                && (rows[i].xd || sfr_other_addr_o === rows[i].a[7:0]),
                "decode");
            cyc();
            chk(ext_rd_n_o === !rows[i].sel[0] && ext_wr_n_o === 1'b1
                && (!rows[i].sel[0] || ext_addr_o === rows[i].a),
                "rd");
            i_rbx_core_model.idle();
            cyc();
        end
        sfr_wr(RBX_AUX_MEM_CTRL_ADDR, 8'h00);
        i_rbx_core_model.xd(1'b1, 1'b1, RBX_EXPANDED_DATA_RAM_TOP, 8'h5a);
        cyc();
        i_rbx_core_model.xd(1'b0, 1'b1, RBX_EXPANDED_DATA_RAM_TOP, 8'h00);
        cyc();
        chk(xdata_rdata_o === 8'h5a && ext_wr_n_o === 1'b1
            && ext_addr_o === 16'h0010 && ext_wdata_o === 8'h00,
            "expanded_data_ram");
        i_rbx_core_model.xd(1'b1, 1'b1, 16'h1234, 8'ha5);
        cyc();
        chk(ext_wr_n_o === 1'b0 && ext_addr_o === 16'h1234
            && ext_wdata_o === 8'ha5, "ext write");
        i_rbx_core_model.idle();
        latch_count(8);
        chk(n == 4, "latch free run");
        sfr_wr(RBX_AUX_MEM_CTRL_ADDR, 8'h01);
        latch_count(8);
        chk(n == 0, "latch suppressed");
        code_table_read_i = 1'b1;
        latch_count(4);
        chk(n == 2, "latch on table read");
        code_table_read_i = 1'b0;
        $display("Test map and strobe done");
        sfr_wr(RBX_AUX_MEM_CTRL_ADDR, 8'h03);
        sfr_wr(RBX_WATCHDOG_CONTROL_ADDR, 8'h04);
        rst_seen = 1'b0;
        srst_seen = 1'b0;
        sfr_wr(RBX_FLASH_CONFIG_ADDR, 8'h02);
        cyc();
        chk(rst_seen === 1'b1 && bank_o === 2'b10
            && srst_seen === 1'b1, "soft reset");
        sfr_rd(RBX_AUX_MEM_CTRL_ADDR);
        chk(rd === 8'h00, "aux after soft reset");
        sfr_rd(RBX_WATCHDOG_CONTROL_ADDR);
        chk(rd === 8'h04, "watchdog bit kept");
        rst_seen = 1'b0;
        srst_seen = 1'b0;
        sfr_wr(RBX_FLASH_CONFIG_ADDR, 8'h03);
        cyc();
        chk(rst_seen === 1'b0 && bank_o === 2'b11
            && srst_seen === 1'b0, "no retrigger");
        watchdog_reset_i = 1'b1;
        cyc();
        watchdog_reset_i = 1'b0;
        cyc();
        chk(bank_o === 2'b10 && boot_code_sel_o === 1'b0
            && srst_seen === 1'b0, "wdt");
        sfr_wr(RBX_FLASH_CONFIG_ADDR, 8'h03);
        rst_seen = 1'b0;
        low_supply_i = 1'b1;
        repeat (3) cyc();
        low_supply_i = 1'b0;
        cyc();
        chk(rst_seen === 1'b0, "short dip");
        low_supply_i = 1'b1;
        repeat (6) cyc();
        low_supply_i = 1'b0;
        cyc();
        chk(rst_seen === 1'b1 && bank_o === 2'b10, "brownout reset");
        sys_rst_i = 1'b1;
        watchdog_reset_i = 1'b1;
        repeat (2) cyc();
        sys_rst_i = 1'b0;
        watchdog_reset_i = 1'b0;
        code_addr_i = RBX_BOOT_TOP;
        cyc();
        chk(bank_o === 2'b00 && boot_code_sel_o === 1'b1, "hard");
        code_addr_i = 16'h2000;
        cyc();
        chk(boot_code_sel_o === 1'b0, "above boot block");
        code_addr_i = 16'h0000;
        sfr_wr(RBX_FLASH_CONFIG_ADDR, 8'h01);
        chk(bank_o === 2'b01 && boot_code_sel_o === 1'b0, "bank 01");
        sfr_wr(RBX_AUX_IRQ_ENABLE_ADDR, 8'h08);
        rst_seen = 1'b0;
        irq_seen = 1'b0;
        low_supply_i = 1'b1;
        repeat (6) cyc();
        chk(irq_seen === 1'b1 && rst_seen === 1'b0, "brownout irq");
        sfr_wr(RBX_AUX_IRQ_ENABLE_ADDR, 8'h00);
        cyc();
        chk(rst_seen === 1'b1 && bank_o === 2'b00
            && boot_code_sel_o === 1'b1, "enable cleared");
        low_supply_i = 1'b0;
        cyc();
        $display("Test reset sources done");
        complete_run();
    end
endmodule
